// [dv/wdt_core_model.sv]
`timescale 1ns/10ps
// ====================
// core model: event pulses, answers a wake with a sleep exit
module wdt_core_model (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             wake_req,
   output wdt_pkg::wdt_core_ev_s ev
);
   logic [3:0] req = 4'h0;
   logic       asleep;
   int         exit_delay = 200;
   int         wait_n;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev     <= '0;
         asleep <= 1'b0;
         wait_n <= 0;
      end else begin
         // sleep exit goes out on the same edge that the wait runs down to zero
         ev <= wdt_pkg::wdt_core_ev_s'(req | ((wait_n == 1) ? 4'h4 : 4'h0));
         if (req[3]) asleep <= 1'b1;
         if (asleep && wake_req) begin
            asleep <= 1'b0;
            wait_n <= exit_delay;
         end else if (wait_n > 0) wait_n <= wait_n - 1;
      end
   end
   task automatic send(input logic [3:0] r);
      req <= r;
      @(posedge pclk);
      req <= 4'h0;
   endtask
endmodule

// [dv/wdt_top_checker.sv]
`timescale 1ns/10ps
// ====================
// port checker
module wdt_top_checker (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic [1:0]  config_enable_mode,
   input logic        sleep_enter,
   input logic        sleep_exit,
   input logic        watchdog_clear_instruction,
   input logic        osc_fail,
   input logic        reset_req,
   input logic        wake_req,
   input logic        timeout_flag,
   input logic        powerdown_flag,
   input logic        irq
);
   logic asleep_h;
   logic en_h;
   logic ctl_wr;
   logic ctl_rd;
   assign ctl_wr = psel && penable && pready && pwrite
                   && paddr == wdt_pkg::ADDR_CONTROL;
   assign ctl_rd = psel && penable && pready && !pwrite
                   && paddr == wdt_pkg::ADDR_CONTROL;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asleep_h <= 1'b0;
         en_h     <= 1'b0;
      end else begin
         if (sleep_enter | sleep_exit) asleep_h <= sleep_enter;
         if (ctl_wr) en_h <= pwdata[0];
      end
   end
   property p_no_rst_sleep; asleep_h |-> !reset_req; endproperty
   property p_wake_asleep; wake_req |-> asleep_h; endproperty
   property p_off_mode;
      config_enable_mode == 2'b00 && $past(config_enable_mode) == 2'b00
      |-> !reset_req && !wake_req;
   endproperty
   property p_soft_off;
      config_enable_mode == 2'b01 && !en_h && !$past(en_h) |-> !reset_req;
   endproperty
   property p_clr_flags;
      watchdog_clear_instruction |-> ##[1:3] (timeout_flag && powerdown_flag);
   endproperty
   property p_slp_flags;
      sleep_enter |-> ##[1:3] (timeout_flag && !powerdown_flag);
   endproperty
   property p_exp_flags;
      reset_req |-> ##[0:2] (!timeout_flag && powerdown_flag);
   endproperty
   property p_rst_pulse; reset_req |=> !reset_req; endproperty
   property p_ctl_read; ctl_rd |-> prdata[31:6] == 26'h0; endproperty
   a_no_rst_sleep: assert property (p_no_rst_sleep)
      else $error("reset request while asleep");
   a_wake_asleep: assert property (p_wake_asleep)
      else $error("wake request while awake");
   a_off_mode: assert property (p_off_mode)
      else $error("expiry in off mode");
   a_soft_off: assert property (p_soft_off)
      else $error("expiry with soft enable clear");
   a_clr_flags: assert property (p_clr_flags)
      else $error("flags not set by clear");
   a_slp_flags: assert property (p_slp_flags)
      else $error("flags wrong after sleep entry");
   a_exp_flags: assert property (p_exp_flags)
      else $error("flags wrong after expiry");
   a_rst_pulse: assert property (p_rst_pulse)
      else $error("reset request longer than one cycle");
   a_ctl_read: assert property (p_ctl_read)
      else $error("control upper bits not zero");
   c_rst: cover property (reset_req);
   c_wake: cover property (wake_req);
   c_irq: cover property ($rose(irq));
endmodule
bind wdt_top wdt_top_checker i_wdt_top_checker (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr),
   .config_enable_mode(config_enable_mode), .sleep_enter(sleep_enter),
   .sleep_exit(sleep_exit), .osc_fail(osc_fail),
   .watchdog_clear_instruction(watchdog_clear_instruction),
   .reset_req(reset_req), .wake_req(wake_req), .irq(irq),
   .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

// [dv/wdt_top_tb_top.sv]
`timescale 1ns/10ps
// ====================
// watchdog bench
module wdt_top_tb_top;
   logic                  pclk, presetn, psel, penable, pwrite, perr;
   logic                  pready, pslverr, reset_req, wake_req, irq;
   logic                  timeout_flag, powerdown_flag;
   logic [1:0]            mode;
   logic [7:0]            paddr;
   logic [31:0]           pwdata, prdata, q;
   wdt_pkg::wdt_core_ev_s ev;
   int                    n_mismatch = 0;
   int                    check_count = 0;
   int                    n;
   localparam int         T = wdt_pkg::OSC_DIV;
   wdt_top i_wdt_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .config_enable_mode(mode), .sleep_enter(ev.sleep_enter),
      .sleep_exit(ev.sleep_exit), .osc_fail(ev.osc_fail),
      .watchdog_clear_instruction(ev.clear_instr), .reset_req(reset_req),
      .wake_req(wake_req), .timeout_flag(timeout_flag),
      .powerdown_flag(powerdown_flag), .irq(irq));
   wdt_core_model i_wdt_core_model (.pclk(pclk), .presetn(presetn),
      .wake_req(wake_req), .ev(ev));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_out(input bit wk, input int lim);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((wk ? wake_req : reset_req) !== 1'b1 && n < lim);
      chk({31'h0, n < lim}, 32'h1);
   endtask
   task idle;
      repeat (8000) @(posedge pclk);
   endtask
   task results;
      if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #4500000;
      n_mismatch++;
      results();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      mode = 2'b01;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, wdt_pkg::ADDR_CONTROL, 0);
      chk(q, 32'h16);
      apb(0, wdt_pkg::ADDR_STATUS, 0);
      chk(q & 32'h3, 32'h3);
      apb(0, 8'h20, 0);
      chk({q[30:0], perr}, 32'h1);
      apb(1, wdt_pkg::ADDR_CONTROL, 32'hff);
      apb(0, wdt_pkg::ADDR_CONTROL, 0);
      chk(q, 32'h3f);
      apb(1, wdt_pkg::ADDR_CONTROL, 32'h26);
      idle();
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      apb(1, wdt_pkg::ADDR_CONTROL, 32'h27);
      mode <= 2'b00;
      idle();
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      mode <= 2'b11;
      apb(1, wdt_pkg::ADDR_CONTROL, 32'h26);
      idle();
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk({31'h0, q != 32'h0}, 32'h1);
      i_wdt_core_model.send(4'h2);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      idle();
      i_wdt_core_model.send(4'h1);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      wait_out(0, 34 * T);
      chk({31'h0, n > 30 * T}, 32'h1);
      chk({timeout_flag, powerdown_flag}, 32'h1);
      // select code zero: smallest valid ratio, 32 ticks
      apb(1, wdt_pkg::ADDR_CONTROL, 32'h0);
      apb(1, wdt_pkg::ADDR_IRQ_EN, 32'h7);
      i_wdt_core_model.send(4'h8);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      chk({timeout_flag, powerdown_flag}, 32'h2);
      wait_out(1, 34 * T);
      chk({31'h0, n > 30 * T}, 32'h1);
      repeat (220) @(posedge pclk);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      chk(irq, 1'b1);
      apb(0, wdt_pkg::ADDR_STATUS, 0);
      chk(q & 32'h1f, 32'h1c);
      apb(1, wdt_pkg::ADDR_IRQ_CLR, 32'h7);
      apb(0, wdt_pkg::ADDR_STATUS, 0);
      chk(q & 32'h1c, 32'h0);
      chk(irq, 1'b0);
      apb(1, wdt_pkg::ADDR_IRQ_EN, 32'h0);
      mode <= 2'b10;
      i_wdt_core_model.send(4'h8);
      idle();
      chk(irq, 1'b0);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      apb(1, wdt_pkg::ADDR_IRQ_EN, 32'h2);
      apb(0, wdt_pkg::ADDR_IRQ_EN, 0);
      chk(q, 32'h2);
      chk(irq, 1'b1);
      // still asleep: always-on mode lets the counter run in sleep
      mode <= 2'b11;
      idle();
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk({31'h0, q != 32'h0}, 32'h1);
      i_wdt_core_model.send(4'h4);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      idle();
      // second reset in mid-run
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, wdt_pkg::ADDR_CONTROL, 0);
      chk(q, 32'h16);
      chk({timeout_flag, powerdown_flag}, 32'h3);
      apb(0, wdt_pkg::ADDR_COUNT, 0);
      chk(q, 32'h0);
      results();
   end
endmodule

// [rtl/wdt_counter.sv]
`timescale 1ns/10ps
// ==========================================================================
// prescaled watchdog counter with ratio decode
module wdt_counter (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick,
   input  wire logic       run,
   input  wire logic       clr,
   input  wire logic [4:0] sel,
   output logic            expire,
   output logic [23:0]     count
);
   // exponent of ratio; reserved codes fold to the minimum
   wire logic       sel_ok = (sel <= wdt_pkg::PS_MAX_VALID);
   wire logic [4:0] expo   = sel_ok ? 5'(sel + 5'(wdt_pkg::PS_EXP_OFFSET))
                                    : 5'(wdt_pkg::PS_EXP_MIN);
   wire logic [23:0] last  = 24'((25'h1 << expo) - 25'h1);
   wire logic        hit   = run && tick && (count >= last);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count  <= 24'h000000;
         expire <= 1'b0;
      end else begin
         expire <= hit;
         if (clr || !run || hit)
            count <= 24'h000000;
         else if (tick)
            count <= count + 24'h000001;
      end
   end
endmodule

// [rtl/wdt_osc_tick.sv]
`timescale 1ns/10ps
// ==========================================================================
// low-frequency tick generator, free running from reset
module wdt_osc_tick (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);
   logic [15:0] div;
   wire         wrap = (div == 16'(wdt_pkg::OSC_DIV - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div  <= 16'h0000;
         tick <= 1'b0;
      end else begin
         div  <= wrap ? 16'h0000 : div + 16'h0001;
         tick <= wrap;
      end
   end
endmodule

// [rtl/wdt_pkg.sv]
//==========================================================================
// Behaviour
// - period select sets nominal timeout from 1 ms up to 256 s
// - after any reset period select gives the 2 s nominal timeout
// - counter clears on reset, oscillator failure and when disabled
// - clear instruction clears counter and prescaler without any reset
// - counter is cleared at the moment of sleep entry
// - enabled in sleep, counter restarts from zero and keeps running
// - counter is cleared again on sleep exit while still asleep; after a watchdog wake it restarts from zero at expiry
// - expiry during sleep never requests a reset
// - expiry during sleep raises a wake request instead
// - watchdog events update timeout and power-down status flags
// - prescale ratio is two to the power of select plus five
// - select codes 10011 and above act as the minimum 1:32 ratio
// - control bits 7-6 read zero, select in 5-1, enable in bit 0
// - counting runs on a time base from the low-frequency oscillator
// - expiry while awake and not cleared requests a device reset
// - in mode 01 the soft enable decides; otherwise it is ignored
// - mode 11 always on, 10 off in sleep, 00 always off
//==========================================================================
package wdt_pkg;

   // ======================================================================
   // register map
   localparam logic [7:0] ADDR_CONTROL  = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_IRQ_EN   = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0c;
   localparam logic [7:0] ADDR_COUNT    = 8'h10;

   // ======================================================================
   // control fields
   localparam int          CTL_EN_BIT    = 0;
   localparam int          CTL_PS_LSB    = 1;
   localparam int          CTL_PS_MSB    = 5;
   localparam logic [4:0]  PS_RESET      = 5'h0b;
   localparam logic [4:0]  PS_MAX_VALID  = 5'h12;
   localparam int          PS_EXP_OFFSET = 5;
   localparam int          PS_EXP_MIN    = 5;
   localparam logic [7:0]  CTL_RESET     = 8'h16;

   // ======================================================================
   // status / interrupt bits
   localparam int          ST_TIMEOUT    = 0;
   localparam int          ST_POWERDOWN  = 1;
   localparam int          ST_EXPIRE     = 2;
   localparam int          IRQ_BITS      = 3;

   // ======================================================================
   // time base: one tick per low_freq_osc period (31 kHz nominal)
   localparam int          CLK_KHZ       = 200000;
   localparam int          OSC_KHZ       = 31;
   localparam int          OSC_DIV       = CLK_KHZ / OSC_KHZ;
   localparam int          CNT_W         = 24;

   typedef enum logic [1:0] {
      WDT_MODE_OFF   = 2'b00,
      WDT_MODE_SOFT  = 2'b01,
      WDT_MODE_NOSLP = 2'b10,
      WDT_MODE_ON    = 2'b11
   } wdt_mode_e;

   typedef enum logic [2:0] {
      WDT_AWAKE  = 3'b001,
      WDT_ASLEEP = 3'b010,
      WDT_WAKING = 3'b100
   } wdt_state_e;

   typedef struct packed {
      logic sleep_enter;
      logic sleep_exit;
      logic clear_instr;
      logic osc_fail;
   } wdt_core_ev_s;

endpackage

// [rtl/wdt_top.sv]
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
// ==========================================================================
// watchdog with sleep control, APB register slave
module wdt_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [1:0]  config_enable_mode,
   input  wire logic        sleep_enter,
   input  wire logic        sleep_exit,
   input  wire logic        watchdog_clear_instruction,
   input  wire logic        osc_fail,
   output logic            reset_req,
   output logic            wake_req,
   output logic            timeout_flag,
   output logic            powerdown_flag,
   output logic            irq
);
   // =======================================================================
   // core events
   wdt_pkg::wdt_core_ev_s ev;
   assign ev.sleep_enter = sleep_enter;
   assign ev.sleep_exit  = sleep_exit;
   assign ev.clear_instr = watchdog_clear_instruction;
   assign ev.osc_fail    = osc_fail;

   // =======================================================================
   // registers
   logic [7:0]                  watchdog_control;
   logic [wdt_pkg::IRQ_BITS-1:0] irq_status;
   logic [wdt_pkg::IRQ_BITS-1:0] irq_enable;
   wdt_pkg::wdt_state_e         state;
   wdt_pkg::wdt_state_e         next_state;

   wire logic        soft_enable_bit = watchdog_control[wdt_pkg::CTL_EN_BIT];
   wire logic [4:0]  period_select   =
      watchdog_control[wdt_pkg::CTL_PS_MSB:wdt_pkg::CTL_PS_LSB];
   wire logic        asleep = (state == wdt_pkg::WDT_ASLEEP);

   // =======================================================================
   // operating mode decode
   wire logic mode_on    = (config_enable_mode == wdt_pkg::WDT_MODE_ON);
   wire logic mode_nslp  = (config_enable_mode == wdt_pkg::WDT_MODE_NOSLP);
   wire logic mode_soft  = (config_enable_mode == wdt_pkg::WDT_MODE_SOFT);
   wire logic run = mode_on
                  | (mode_nslp & ~asleep)
                  | (mode_soft & soft_enable_bit);

   // clears come in synchronous to pclk, which is the tick domain as well,
   // and clr_q stretches each event pulse into a clear two cycles long
   wire logic clr = ev.clear_instr
                  | ev.osc_fail
                  | (ev.sleep_enter & ~asleep)
                  | (ev.sleep_exit & asleep);
   logic      clr_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         clr_q <= 1'b0;
      else
         clr_q <= clr;
   end

   // =======================================================================
   // counter
   logic        tick;
   logic        expire;
   logic [23:0] count;

   wdt_osc_tick u_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick)
   );

   wdt_counter u_cnt (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .run     (run),
      .clr     (clr | clr_q),
      .sel     (period_select),
      .expire  (expire),
      .count   (count)
   );

   // =======================================================================
   // sleep state
   always_comb begin
      next_state = state;
      case (state)
         wdt_pkg::WDT_AWAKE: begin
            if (ev.sleep_enter)
               next_state = wdt_pkg::WDT_ASLEEP;
         end
         wdt_pkg::WDT_ASLEEP: begin
            if (ev.sleep_exit || expire)
               next_state = wdt_pkg::WDT_WAKING;
         end
         wdt_pkg::WDT_WAKING: begin
            next_state = wdt_pkg::WDT_AWAKE;
         end
         default: begin
            next_state = wdt_pkg::WDT_AWAKE;
         end
      endcase
   end

   wire logic exp_awake = expire & ~asleep;
   wire logic exp_sleep = expire & asleep;

   // =======================================================================
   // status flags and core requests
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state          <= wdt_pkg::WDT_AWAKE;
         reset_req      <= 1'b0;
         wake_req       <= 1'b0;
         timeout_flag   <= 1'b1;
         powerdown_flag <= 1'b1;
      end else begin
         state     <= next_state;
         reset_req <= exp_awake;
         wake_req  <= exp_sleep;
         if (expire)
            timeout_flag <= 1'b0;
         else if (ev.clear_instr || ev.sleep_enter)
            timeout_flag <= 1'b1;
         if (ev.sleep_enter)
            powerdown_flag <= 1'b0;
         else if (ev.clear_instr || exp_awake)
            powerdown_flag <= 1'b1;
      end
   end

   // =======================================================================
   // APB decode
   wire logic acc     = psel & penable;
   wire logic wr      = acc & pwrite;
   wire logic hit_ctl = (paddr == wdt_pkg::ADDR_CONTROL);
   wire logic hit_st  = (paddr == wdt_pkg::ADDR_STATUS);
   wire logic hit_en  = (paddr == wdt_pkg::ADDR_IRQ_EN);
   wire logic hit_clr = (paddr == wdt_pkg::ADDR_IRQ_CLR);
   wire logic hit_cnt = (paddr == wdt_pkg::ADDR_COUNT);
   wire logic mapped  = hit_ctl | hit_st | hit_en | hit_clr | hit_cnt;

   wire logic [wdt_pkg::IRQ_BITS-1:0] ev_set = {expire, ev.sleep_enter,
                                                exp_sleep};
   wire logic [wdt_pkg::IRQ_BITS-1:0] ev_clr =
      (wr & hit_clr) ? pwdata[wdt_pkg::IRQ_BITS-1:0] : '0;

   wire logic [31:0] rd_mux =
        hit_ctl ? {24'h000000, 2'b00, watchdog_control[5:0]}
      : hit_st  ? {27'h0000000, irq_status, powerdown_flag, timeout_flag}
      : hit_en  ? {29'h00000000, irq_enable}
      : hit_cnt ? {8'h00, count}
      : 32'h00000000;

   // =======================================================================
   // register write and read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         watchdog_control <= wdt_pkg::CTL_RESET;
         irq_enable       <= '0;
      end else if (wr && hit_ctl) begin
         watchdog_control <= {2'b00, pwdata[5:0]};
      end else if (wr && hit_en) begin
         irq_enable <= pwdata[wdt_pkg::IRQ_BITS-1:0];
      end
   end

   // set wins over a simultaneous clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_status <= '0;
      else
         irq_status <= (irq_status & ~ev_clr) | ev_set;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h00000000;
         irq     <= |(irq_status & irq_enable);
      end
   end
endmodule
